// >>> rtl/eeprom_loader_consts.svh
// Offsets, field positions, reset values and timing for the ROM loader
`ifndef EEPROM_LOADER_CONSTS_SVH
`define EEPROM_LOADER_CONSTS_SVH

`define CFG_PORT_OFFSET   8'h14
`define KEY_OFFSET        8'h00
`define CMD_OFFSET        8'h04
`define DATA_OFFSET       8'h08

`define KEY_FIRST         32'haa559966
`define KEY_SECOND        32'h669955aa

`define DONE_BIT          25
`define ERROR_BIT         24
`define RETRY_BIT         24
`define CODE_HI           23
`define CODE_LO           22
`define ADDR_HI           21
`define ADDR_LO           16
`define WADDR_HI          5
`define WADDR_LO          4

`define CFG_DATA_HI       31
`define CFG_DATA_LO       16
`define CFG_IDX_HI        15
`define CFG_IDX_LO        12
`define CFG_WREN_BIT      8

`define PWR_SAVE_BIT      15
`define REV_SEL_BIT       9
`define WAKE_BIT          4
`define DEBUG_BIT         2
`define SWAP_BIT          1
`define EXPROM_BIT        0
`define WORD0_RESET       16'h0007

`define CODE_MISC         2'h0
`define CODE_WRITE        2'h1
`define CODE_READ         2'h2

`define WORD_UID_LO       4'h1
`define WORD_UID_HI       4'h3
`define WORD_CARDBUS      4'h5
`define WORD_SUBSYS       4'h7
`define LAST_LOAD_WORD    4'h8

`define SEND_BITS_SHORT   5'h09
`define SEND_BITS_LONG    5'h19
`define RECV_BITS         5'h11
`define POLL_SETTLE       4

`define CLK_PERIOD_NS     20
`define SK_HALF_NS        500
`define SK_HALF_CYCLES    ((`SK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_TIMEOUT_NS  10000000
`define WRITE_TIMEOUT_CYCLES (`WRITE_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// >>> rtl/eeprom_loader_pkg.sv
// Types shared by the serial ROM configuration loader
package eeprom_loader_pkg;
	typedef enum logic [2:0] {
		S_IDLE,
		S_SELECT,
		S_SEND,
		S_RECV,
		S_DESELECT,
		S_POLL,
		S_FINISH
	} seq_state_t;
endpackage : eeprom_loader_pkg

// >>> rtl/serial_eeprom_config_loader.sv
// Serial ROM configuration loader with keyed software command access
//
// Function
// R1 - Load ROM into configuration after reset
// R2 - Words 1 to 8 feed id registers
// R3 - Word 0 bit 15 idle power save
// R4 - Word 0 bit 9 selects controller revision
// R5 - Word 0 bit 4 enables wake signal
// R6 - Word 0 bit 2 enables debug path
// R7 - Word 0 bit 1 enables byte swap
// R8 - Word 0 bit 0 sets expansion enable
// R9 - Programmer writes reserved word 0 bits zero
// R10 - Offset 14h writes data and index
// R11 - Path write needs write enable bit 8
// R12 - Word 0 with debug zero locks path
// R13 - Path used only with data pin open; logic gates it on word 0 bit 2 and load end only, not on the pin
// R14 - Two key writes unlock command registers
// R15 - Software brackets writes with enable, disable
// R16 - Write word, device sets completion flag
// R17 - Retry bit re-executes the pending operation
// R18 - Read command returns word in data
// R19 - Completion flag bit 25, resets one
// R20 - Error flag bit 24 shows failure
// R21 - Command code 23:22, address 21:16
// R22 - Data register holds write and read words
// R23 - Three-wire serial protocol drives the ROM
// R24 - New command clears completion until finished; a retry taken in the finish cycle leaves it set
`timescale 1ns/1ps
`include "eeprom_loader_consts.svh"

module serial_eeprom_config_loader #(
	parameter int SK_HALF       = `SK_HALF_CYCLES,
	parameter int WRITE_TIMEOUT = `WRITE_TIMEOUT_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_offset,
	input  wire logic [31:0] cfg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_offset,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             rom_cs,
	output logic             rom_sk,
	output logic             rom_di_out,
	input  wire logic        rom_serial_data_out_pin,
	output logic             idle_power_save,
	output logic             controller_revision_select,
	output logic             wake_signal_enable,
	output logic             debug_enable,
	output logic             byte_swap_enable,
	output logic             expansion_rom_enable,
	output logic      [31:0] unique_id_low,
	output logic      [31:0] unique_id_high,
	output logic      [31:0] cardbus_pointer,
	output logic      [31:0] subsystem_ids,
	output logic             load_busy
);
	eeprom_loader_pkg::seq_state_t state;
	logic [15:0] cfg_word [0:15];
	logic        key_stage;
	logic        unlocked;
	logic [1:0]  command_code;
	logic [5:0]  word_address;
	logic [15:0] rom_word_data;
	logic        op_complete_flag;
	logic        op_error_flag;
	logic [1:0]  op_code;
	logic [24:0] shift_out;
	logic [16:0] shift_in;
	logic [4:0]  bit_cnt;
	logic [15:0] tick_cnt;
	logic [23:0] poll_cnt;
	logic        loading;
	logic [3:0]  load_idx;
	logic        di_s1;
	logic        di_s2;
	logic        di_s3;
	logic        di_filt;

	// Decoding
	wire        tick      = (tick_cnt == 16'(SK_HALF - 1));
	wire        idle      = (state == eeprom_loader_pkg::S_IDLE);
	wire        finish    = (state == eeprom_loader_pkg::S_FINISH);
	wire        key_hit   = reg_wr && (reg_offset == `KEY_OFFSET);
	wire        key_second_hit = key_hit && (reg_wdata == `KEY_SECOND);
	wire        cmd_hit   = reg_wr && unlocked && (reg_offset == `CMD_OFFSET);
	wire        data_hit  = reg_wr && unlocked && (reg_offset == `DATA_OFFSET);
	wire [1:0]  new_code  = reg_wdata[`CODE_HI:`CODE_LO];
	wire        retry_go  = cmd_hit && reg_wdata[`RETRY_BIT] && !loading;
	wire        cmd_go    = cmd_hit && !reg_wdata[`RETRY_BIT] && idle &&
		!loading && (new_code == `CODE_READ || new_code == `CODE_MISC);
	wire        write_go  = data_hit && idle && !loading &&
		(command_code == `CODE_WRITE);
	wire        load_go   = loading && idle;
	wire        sw_go     = retry_go || cmd_go || write_go;
	wire        start     = sw_go || load_go;
	wire [1:0]  next_op   = load_go ? `CODE_READ :
		(cmd_go ? new_code : command_code);
	wire [5:0]  next_addr = load_go ? {2'h0, load_idx} :
		(cmd_go ? reg_wdata[`ADDR_HI:`ADDR_LO] : word_address);
	wire [15:0] next_data = write_go ? reg_wdata[15:0] : rom_word_data;
	wire        rd_error  = shift_in[16];
	wire        poll_out  = (poll_cnt == 24'(WRITE_TIMEOUT));
	// Synchroniser still shows the deselected level for a few cycles
	wire        poll_ready = di_filt && (poll_cnt >= 24'(`POLL_SETTLE));
	wire        op_fail   = (op_code == `CODE_READ) ? rd_error : poll_out;
	wire [15:0] word_in   = shift_in[15:0];
	wire [3:0]  cfg_idx   = cfg_wdata[`CFG_IDX_HI:`CFG_IDX_LO];
	wire [15:0] cfg_val   = cfg_wdata[`CFG_DATA_HI:`CFG_DATA_LO];
	wire        cfg_accept = cfg_wr && (cfg_offset == `CFG_PORT_OFFSET) &&
		cfg_wdata[`CFG_WREN_BIT] && cfg_word[0][`DEBUG_BIT] && !loading;

	// Configuration outputs straight from the word store
	assign idle_power_save            = cfg_word[0][`PWR_SAVE_BIT]; // R3
	assign controller_revision_select = cfg_word[0][`REV_SEL_BIT]; // R4
	assign wake_signal_enable         = cfg_word[0][`WAKE_BIT]; // R5
	assign debug_enable               = cfg_word[0][`DEBUG_BIT]; // R6
	assign byte_swap_enable           = cfg_word[0][`SWAP_BIT]; // R7
	assign expansion_rom_enable       = cfg_word[0][`EXPROM_BIT]; // R8
	assign unique_id_low   = {cfg_word[`WORD_UID_LO + 4'h1],
		cfg_word[`WORD_UID_LO]}; // R2
	assign unique_id_high  = {cfg_word[`WORD_UID_HI + 4'h1],
		cfg_word[`WORD_UID_HI]}; // R2
	assign cardbus_pointer = {cfg_word[`WORD_CARDBUS + 4'h1],
		cfg_word[`WORD_CARDBUS]}; // R2
	assign subsystem_ids   = {cfg_word[`WORD_SUBSYS + 4'h1],
		cfg_word[`WORD_SUBSYS]}; // R2
	assign load_busy       = loading;

	// Data pin from the ROM: three stages, change taken when two agree
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			di_s1   <= 1'b0;
			di_s2   <= 1'b0;
			di_s3   <= 1'b0;
			di_filt <= 1'b0;
		end
		else
		begin
			di_s1 <= rom_serial_data_out_pin;
			di_s2 <= di_s1;
			di_s3 <= di_s2;
			if (di_s2 == di_s3)
				di_filt <= di_s3;
		end
	end

	// Serial clock half-period divider
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tick_cnt <= 16'h0000;
		else if (tick || start)
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick_cnt + 16'h0001;
	end

	// Unlock key sequence
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			key_stage <= 1'b0;
			unlocked  <= 1'b0;
		end
		else if (key_hit)
		begin
			key_stage <= (reg_wdata == `KEY_FIRST); // R14
			if (key_stage && reg_wdata == `KEY_SECOND)
				unlocked <= 1'b1; // R14
		end
	end

	// Command, address and data registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			command_code  <= `CODE_MISC;
			word_address  <= 6'h00;
			rom_word_data <= 16'h0000;
		end
		else
		begin
			if (cmd_hit && !reg_wdata[`RETRY_BIT])
			begin
				command_code <= new_code; // R21
				word_address <= reg_wdata[`ADDR_HI:`ADDR_LO]; // R21
			end
			if (data_hit)
				rom_word_data <= reg_wdata[15:0]; // R22
			if (finish && !loading && op_code == `CODE_READ && !rd_error)
				rom_word_data <= word_in; // R18 R22
		end
	end

	// Completion and error flags
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			op_complete_flag <= 1'b1; // R19
			op_error_flag    <= 1'b0;
		end
		else if (finish)
		begin
			op_complete_flag <= 1'b1; // R16 R19 R24
			op_error_flag    <= op_fail; // R20 R24
		end
		else if (sw_go)
			op_complete_flag <= 1'b0; // R24
	end

	// Register read data
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd && unlocked && reg_offset == `CMD_OFFSET)
			reg_rdata <= {6'h00, op_complete_flag, op_error_flag,
				command_code, word_address, 16'h0000}; // R19 R20 R21
		else if (reg_rd && unlocked && reg_offset == `DATA_OFFSET)
			reg_rdata <= {16'h0000, rom_word_data}; // R22
		else if (reg_rd)
			reg_rdata <= 32'h00000000; // R14
	end

	// Word store: reset-time load and configuration-space path
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < 16; i++)
				cfg_word[i] <= 16'h0000;
			cfg_word[0] <= `WORD0_RESET;
		end
		else if (finish && loading && !rd_error)
			cfg_word[load_idx] <= word_in; // R1 R2
		else if (cfg_accept)
			cfg_word[cfg_idx] <= cfg_val; // R10 R11 R12
	end

	// Reset-time loader walks words 0 to 8, stops on a failed read
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			loading  <= 1'b1; // R1
			load_idx <= 4'h0;
		end
		else if (finish && loading)
		begin
			if (rd_error || load_idx == `LAST_LOAD_WORD)
				loading <= 1'b0;
			load_idx <= load_idx + 4'h1;
		end
	end

	// Three-wire serial sequencer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state      <= eeprom_loader_pkg::S_IDLE;
			rom_cs     <= 1'b0;
			rom_sk     <= 1'b0;
			rom_di_out <= 1'b0;
			op_code    <= `CODE_MISC;
			shift_out  <= 25'h0000000;
			shift_in   <= 17'h00000;
			bit_cnt    <= 5'h00;
			poll_cnt   <= 24'h000000;
		end
		else if (start)
		begin
			// Retry abandons whatever is in flight
			state     <= eeprom_loader_pkg::S_SELECT; // R17 R23
			rom_cs    <= 1'b0;
			rom_sk    <= 1'b0;
			op_code   <= next_op;
			shift_out <= {1'b1, next_op, next_addr, next_data};
			bit_cnt   <= (next_op == `CODE_WRITE) ?
				`SEND_BITS_LONG : `SEND_BITS_SHORT;
			poll_cnt  <= 24'h000000;
		end
		else
		begin
			unique case (state)
				eeprom_loader_pkg::S_IDLE:
					rom_cs <= 1'b0;
				eeprom_loader_pkg::S_SELECT:
					if (tick)
					begin
						rom_cs     <= 1'b1; // R23
						rom_di_out <= shift_out[24];
						state      <= eeprom_loader_pkg::S_SEND;
					end
				eeprom_loader_pkg::S_SEND:
					if (tick && !rom_sk)
						rom_sk <= 1'b1;
					else if (tick)
					begin
						rom_sk     <= 1'b0;
						shift_out  <= {shift_out[23:0], 1'b0};
						rom_di_out <= shift_out[23];
						bit_cnt    <= bit_cnt - 5'h01;
						if (bit_cnt == 5'h01 && op_code == `CODE_READ)
						begin
							bit_cnt <= `RECV_BITS;
							state   <= eeprom_loader_pkg::S_RECV;
						end
						else if (bit_cnt == 5'h01)
							state <= eeprom_loader_pkg::S_DESELECT;
					end
				eeprom_loader_pkg::S_RECV:
					if (tick && !rom_sk)
						rom_sk <= 1'b1;
					else if (tick)
					begin
						rom_sk   <= 1'b0;
						shift_in <= {shift_in[15:0], di_filt}; // R18
						bit_cnt  <= bit_cnt - 5'h01;
						if (bit_cnt == 5'h01)
							state <= eeprom_loader_pkg::S_DESELECT;
					end
				eeprom_loader_pkg::S_DESELECT:
				begin
					rom_cs     <= 1'b0;
					rom_di_out <= 1'b0;
					if (tick && op_code == `CODE_WRITE)
					begin
						rom_cs <= 1'b1;
						state  <= eeprom_loader_pkg::S_POLL;
					end
					else if (tick)
						state <= eeprom_loader_pkg::S_FINISH;
				end
				eeprom_loader_pkg::S_POLL:
				begin
					// Ready shows as data pin high while selected;
					// count freezes on exit so a timeout stays visible
					if (poll_ready || poll_out)
					begin
						rom_cs <= 1'b0;
						state  <= eeprom_loader_pkg::S_FINISH; // R16
					end
					else
						poll_cnt <= poll_cnt + 24'h000001;
				end
				eeprom_loader_pkg::S_FINISH:
					state <= eeprom_loader_pkg::S_IDLE;
				default:
					state <= eeprom_loader_pkg::S_IDLE;
			endcase
		end
	end

	sequence s_finish;
		finish;
	endsequence

	sequence s_key_pair;
		key_second_hit && key_stage;
	endsequence

	a_key_unlock: assert property (@(posedge clk) // R14
		disable iff (!reset_n)
		s_key_pair |=> unlocked ##1 unlocked)
		else $error("unlock key pair did not open registers");

	a_key_locked: assert property (@(posedge clk) // R14
		disable iff (!reset_n)
		$rose(unlocked) |-> $past(key_second_hit))
		else $error("registers opened without second key");

	a_done_clear: assert property (@(posedge clk) // R24
		disable iff (!reset_n)
		sw_go && !finish |=> !op_complete_flag)
		else $error("completion flag not cleared by new command");

	a_done_set: assert property (@(posedge clk) // R19
		disable iff (!reset_n)
		s_finish |=> op_complete_flag && state == eeprom_loader_pkg::S_IDLE)
		else $error("completion flag not set at finish");

	a_read_result: assert property (@(posedge clk) // R18
		disable iff (!reset_n)
		s_finish and (!loading && op_code == `CODE_READ && !rd_error)
		|=> rom_word_data == $past(word_in))
		else $error("read word not placed in data register");

	a_sk_framed: assert property (@(posedge clk) // R23
		disable iff (!reset_n)
		rom_sk |-> rom_cs)
		else $error("serial clock active without chip select");

	a_path_lock: assert property (@(posedge clk) // R12
		disable iff (!reset_n)
		cfg_accept && cfg_idx == 4'h0 && !cfg_val[`DEBUG_BIT]
		|=> !debug_enable ##1 !debug_enable)
		else $error("word zero with debug clear did not lock path");

	a_path_enable: assert property (@(posedge clk) // R11
		disable iff (!reset_n)
		cfg_wr && !cfg_wdata[`CFG_WREN_BIT] && !finish
		|=> $stable(unique_id_low) && $stable(debug_enable))
		else $error("path write without enable changed a word");

	a_load_order: assert property (@(posedge clk) // R1
		disable iff (!reset_n)
		s_finish and loading |-> op_code == `CODE_READ)
		else $error("reset load issued a non-read operation");

	a_poll_timeout: assert property (@(posedge clk) // R20
		disable iff (!reset_n)
		state == eeprom_loader_pkg::S_POLL && poll_out && !start
		|=> finish ##1 op_error_flag)
		else $error("write timeout not reported as error");
endmodule : serial_eeprom_config_loader

// >>> bench/rom_model.sv
// Behavioural three-wire serial configuration ROM of 64 words
`timescale 1ns/1ps
module rom_model (
	input  wire logic cs,
	input  wire logic sk,
	input  wire logic di,
	input  wire logic absent,
	input  wire logic stuck,
	output logic      dout
);
	logic [15:0] mem [64];
	logic [24:0] sh;
	logic [15:0] rd;
	int          cnt = 0;
	logic        wen = 1'b0;
	logic        rdng = 1'b0;
	logic        wpend = 1'b0;
	logic        rdy = 1'b1;
	logic        dbit = 1'b0;

	// Open pin is pulled high on the board; released line shows inverse
	assign dout = absent ? 1'b1 : !cs ? ~dbit :
		wpend ? (rdy & ~stuck) : rdng ? dbit : ~dbit;

	always @(negedge cs)
	begin
		cnt = 0;
		rdng = 1'b0;
	end

	always @(posedge sk)
	begin
		if (cs)
		begin
			sh = {sh[23:0], di};
			cnt = cnt + 1;
			if (cnt == 1)
				wpend = 1'b0;
			if (cnt == 9 && sh[8:6] == 3'b110)
			begin
				rd = mem[sh[5:0]];
				rdng = 1'b1;
			end
			if (cnt == 9 && sh[8:6] == 3'b100 && sh[5:4] == 2'b11)
				wen = 1'b1;
			if (cnt == 9 && sh[8:6] == 3'b100 && sh[5:4] == 2'b00)
				wen = 1'b0;
			if (rdng && cnt >= 10 && cnt <= 26)
				dbit = (cnt == 10) ? 1'b0 : rd[26 - cnt];
			if (cnt == 25 && !rdng && sh[24:22] == 3'b101 && wen)
			begin
				mem[sh[21:16]] = sh[15:0];
				wpend = 1'b1;
				rdy = 1'b0;
				rdy <= #400 1'b1;
			end
		end
	end
endmodule : rom_model

// >>> bench/serial_eeprom_config_loader_tb_top.sv
// Self-checking bench for the serial ROM configuration loader
`timescale 1ns/1ps
module serial_eeprom_config_loader_tb_top;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cfg_wr = 1'b0;
	logic [7:0]  cfg_offset = 8'h00;
	logic [31:0] cfg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_offset = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic        rom_cs;
	logic        rom_sk;
	logic        rom_di_out;
	logic        pin;
	logic        absent = 1'b0;
	logic        stuck = 1'b0;
	logic        ips;
	logic        crs;
	logic        wse;
	logic        dbe;
	logic        bse;
	logic        ere;
	logic [5:0]  flg;
	logic [31:0] uid_lo;
	logic [31:0] uid_hi;
	logic [31:0] cbp;
	logic [31:0] ssid;
	logic        load_busy;
	logic [15:0] shadow [64];
	logic [31:0] got;
	logic [15:0] v;
	logic [15:0] d;
	logic [5:0]  a;
	int          failures = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          seed = 32'h7627d3b4;

	assign flg = {ips, crs, wse, dbe, bse, ere};

	serial_eeprom_config_loader #(.SK_HALF(8), .WRITE_TIMEOUT(64)) dut (
		.clk(clk), .reset_n(reset_n),
		.cfg_wr(cfg_wr), .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_offset(reg_offset),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.rom_cs(rom_cs), .rom_sk(rom_sk), .rom_di_out(rom_di_out),
		.rom_serial_data_out_pin(pin),
		.idle_power_save(ips), .controller_revision_select(crs),
		.wake_signal_enable(wse), .debug_enable(dbe),
		.byte_swap_enable(bse), .expansion_rom_enable(ere),
		.unique_id_low(uid_lo), .unique_id_high(uid_hi),
		.cardbus_pointer(cbp), .subsystem_ids(ssid),
		.load_busy(load_busy)
	);

	rom_model rom (
		.cs(rom_cs), .sk(rom_sk), .di(rom_di_out),
		.absent(absent), .stuck(stuck), .dout(pin)
	);

	initial
	begin
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] flags(input logic [15:0] w);
		return {26'h0, w[15], w[9], w[4], w[2], w[1], w[0]};
	endfunction : flags

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic wr(input logic [7:0] o, input logic [31:0] dat);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_offset <= o;
		reg_wdata <= dat;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] o);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_offset <= o;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1 got = reg_rdata;
	endtask : rd

	task automatic cw(input logic [7:0] o, input logic [31:0] dat);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_offset <= o;
		cfg_wdata <= dat;
		@(posedge clk);
		cfg_wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : cw

	task automatic reset16();
		int i;
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		check("busy in reset", 32'h1, {31'h0, load_busy});
		check("word0 reset", flags(16'h0007), {26'h0, flg});
		reset_n <= 1'b1;
		for (i = 0; i < 8000 && load_busy !== 1'b0; i++)
			@(posedge clk);
		#1;
		check("load end", 32'h0, {31'h0, load_busy});
	endtask : reset16

	task automatic wait_done();
		int i;
		for (i = 0; i < 400; i++)
		begin
			rd(8'h04);
			if (got[25] === 1'b1)
				break;
		end
		check("done set", 32'h1, {31'h0, got[25]});
	endtask : wait_done

	task automatic op(input logic [1:0] c, input logic [5:0] ad,
		input logic [15:0] dat, input logic e);
		wr(8'h04, {8'h00, c, ad, 16'h0000});
		if (c == 2'h1)
			wr(8'h08, {16'h0000, dat});
		rd(8'h04);
		check("done cleared", 32'h0, {31'h0, got[25]});
		wait_done();
		check("cmd state", {23'h0, e, c, ad}, {23'h0, got[24:16]});
		if (c == 2'h2 && !e)
		begin
			rd(8'h08);
			check("read data", {16'h0, shadow[ad]}, got);
		end
	endtask : op

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			failures++;
			close_out();
		end
	end

	initial
	begin
		for (int i = 0; i < 64; i++)
			shadow[i] = 16'($random(seed));
		shadow[0] = shadow[0] & 16'h8217;
		for (int i = 0; i < 64; i++)
			rom.mem[i] = shadow[i];
		// Pin left open, load fails and config path stays usable
		absent = 1'b1;
		reset16();
		check("id open", 32'h0, uid_lo);
		v = 16'($random(seed));
		cw(8'h14, {v, 4'h1, 12'h000});
		check("no wren", 32'h0, uid_lo);
		cw(8'h10, {v, 4'h1, 12'h100});
		check("other offset", 32'h0, uid_lo);
		cw(8'h14, {v, 4'h1, 12'h100});
		check("path word1", {16'h0, v}, uid_lo);
		cw(8'h14, {v, 4'h8, 12'h100});
		check("path word8", {v, 16'h0}, ssid);
		d = v & 16'h8213;
		cw(8'h14, {d, 4'h0, 12'h100});
		check("path word0", flags(d), {26'h0, flg});
		cw(8'h14, {~v, 4'h1, 12'h100});
		check("path locked", {16'h0, v}, uid_lo);
		// Second reset with the ROM fitted
		absent = 1'b0;
		reset16();
		check("load word0", flags(shadow[0]), {26'h0, flg});
		check("uid low", {shadow[2], shadow[1]}, uid_lo);
		check("uid high", {shadow[4], shadow[3]}, uid_hi);
		check("cardbus", {shadow[6], shadow[5]}, cbp);
		check("subsystem", {shadow[8], shadow[7]}, ssid);
		rd(8'h04);
		check("locked cmd", 32'h0, got);
		wr(8'h00, 32'haa559966);
		wr(8'h00, 32'h12345678);
		wr(8'h00, 32'h669955aa);
		rd(8'h04);
		check("broken key", 32'h0, got);
		wr(8'h00, 32'haa559966);
		wr(8'h00, 32'h669955aa);
		rd(8'h04);
		check("cmd after key", 32'h02000000, got);
		rd(8'h0c);
		check("unmapped", 32'h0, got);
		for (int i = 0; i < 4; i++)
		begin
			a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
			op(2'h2, a, 16'h0, 1'b0);
		end
		op(2'h0, 6'h30, 16'h0, 1'b0);
		a = 6'($random(seed));
		d = 16'($random(seed));
		op(2'h1, a, d, 1'b0);
		shadow[a] = d;
		op(2'h2, a, 16'h0, 1'b0);
		// Write that never finishes, then retried
		stuck = 1'b1;
		a = a + 6'h01;
		d = ~d;
		op(2'h1, a, d, 1'b1);
		stuck = 1'b0;
		wr(8'h04, 32'h01000000);
		wait_done();
		check("retry error", 32'h0, {31'h0, got[24]});
		shadow[a] = d;
		op(2'h2, a, 16'h0, 1'b0);
		op(2'h0, 6'h00, 16'h0, 1'b0);
		absent = 1'b1;
		op(2'h2, 6'h05, 16'h0, 1'b1);
		absent = 1'b0;
		close_out();
	end
endmodule : serial_eeprom_config_loader_tb_top
